// ### pia_arbiter.sv
`timescale 1ns/1ps
// Functional notes
// R01: Every source sits at one of five levels; resets restore defaults.
// R02: Illegal op, stack overflow, misalign, top soft trap always enabled.
// R03: Step counter, breakpoint, trace gated by control-status enable bits.
// R04: Defaults: L2 trap and slots 4-6, L1 trap and slots 1-3, lowest trap LP.
// R05: Three level-0 sources may move into the level-1 slots.
// R06: Three level-0 sources may move into level-2 slots; one is fast.
// R07: Slot candidates are level-0 sources plus debug tx-empty and rx-full.
// R08: Core software traps are never gated by an enable.
// R09: Within a level the lowest vector number wins.
// R10: Each level gives a pending flag and a winning index.
// R11: Higher level wins; core told only when priority is sufficient.
// R12: Core-generated requests are edge detected into pending events.
// R13: Hardware acknowledge clears the pending core-generated request.
// R14: In wait or stop, enabled pending requests ask for a clock restart.
// R15: Wait modes alike, stop modes alike; drive interrupt-asserted output.
// R16: After reset the initial fetch address is driven.
// R17: Vector address is base register joined with vector number.
// R18: Core mask bits 00 all, 01 mask L0, 10 mask L0-1, 11 only L3.
// R19: Level code 00 none/LP, 01 L0, 10 L1, 11 L2 or 3.
// R20: Slot six source with a non-subroutine first insn is a fast interrupt.
// R21: Peripherals gate their own requests; no per-peripheral enable here.
// R22: Software should keep the fast interrupt alone at level 2.
// R23: A redirected source loses its own vector, using only the slot vector.
// R24: All arbitration state is clocked on mclk and cleared by reset.
module pia_arbiter (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // Core exception and trap requests, level signals from the core
  input  wire logic        core_illegal_req,
  input  wire logic        core_stack_ov_req,
  input  wire logic        core_misalign_req,
  input  wire logic        core_step_req,
  input  wire logic        core_brk_req,
  input  wire logic        core_trace_req,
  input  wire logic        soft_trap_top,
  input  wire logic        soft_trap_l2,
  input  wire logic        soft_trap_l1,
  input  wire logic        soft_trap_lowest,
  input  wire logic        debug_tx_empty_req,
  input  wire logic        debug_rx_full_req,
  input  wire logic        hw_int_ack,
  // Level-0 peripheral requests, index 0 is the lowest level-0 vector
  input  wire logic [21:0] periph_req,
  // Control and status bits
  input  wire logic [4:0]  ctrl_status_reg,
  input  wire logic [12:0] vector_base_reg,
  input  wire logic [6:0]  level1_slot_a,
  input  wire logic [6:0]  level1_slot_b,
  input  wire logic [6:0]  level1_slot_c,
  input  wire logic [6:0]  level2_slot_a,
  input  wire logic [6:0]  level2_slot_b,
  input  wire logic [6:0]  level2_fast_slot,
  input  wire logic        fast_first_is_sub,
  input  wire logic [1:0]  core_mask_bits,
  input  wire logic        lowpower_wait_mode,
  input  wire logic        lowpower_stop_mode,
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  // To the core
  output logic             irq_to_core,
  output logic [20:0]      vector_addr,
  output logic [6:0]       winning_vector,
  output logic [1:0]       current_level_code,
  output logic             fast_irq,
  output logic [4:0]       pending_core_events,
  // Wake-up paths
  output logic             clock_restart_req,
  output logic             irq_asserted
);
  localparam int unsigned NC = 5;
  localparam int unsigned NS = 3;
  // Pending-event bit of each core trap; bit 0 stays unused
  localparam int unsigned PEND_TOP = 1;
  localparam int unsigned PEND_L2  = 2;
  localparam int unsigned PEND_L1  = 3;
  localparam int unsigned PEND_LOW = 4;
  // Level-3 encoder index of the top trap
  localparam logic [6:0] L3_TRAP_IDX = 7'h08;

  // Edge detection of core-generated events
  logic [NC-1:0] core_lvl;
  logic [NC-1:0] core_prev_reg;
  logic [NC-1:0] core_pend_reg;
  logic [NC-1:0] core_pend_next;
  logic [NC-1:0] core_rise;
  logic [NC-1:0] core_ack_hit;

  assign core_lvl  = {soft_trap_lowest, soft_trap_l1, soft_trap_l2,
                      soft_trap_top, 1'b0};
  assign core_rise = core_lvl & ~core_prev_reg; // [R12]

  // Captured winner, registered each cycle
  logic [6:0]       win_vec_reg;
  logic [6:0]       win_vec_next;
  pia_pkg::pia_level_t win_lvl_reg;
  pia_pkg::pia_level_t win_lvl_next;
  logic             irq_reg;
  logic             irq_next;
  logic             fast_reg;
  logic             fast_next;
  logic             rst_done_reg;
  logic             restart_next;

  // Acknowledge clears the trap that was presented; a new edge wins
  genvar c;
  generate
    for (c = 0; c < NC; c++) begin : g_core
      assign core_ack_hit[c] = hw_int_ack && irq_reg &&
        (win_vec_reg == ((c == 0) ? 7'h7f : pia_pkg::VEC_TRAP_TOP + 7'(c - 1)));
      assign core_pend_next[c] = core_rise[c] |
                                 (core_pend_reg[c] & ~core_ack_hit[c]); // [R13]
    end
  endgenerate

  // Slot selection: each slot holds the vector number it carries
  logic [6:0] slot_sel [6];
  assign slot_sel[0] = level1_slot_a;
  assign slot_sel[1] = level1_slot_b;
  assign slot_sel[2] = level1_slot_c;
  assign slot_sel[3] = level2_slot_a;
  assign slot_sel[4] = level2_slot_b;
  assign slot_sel[5] = level2_fast_slot;

  // Candidate space: debug tx/rx plus level-0 sources, vectors 8 upward
  localparam int unsigned NCAND = pia_pkg::L0_COUNT + 2;
  logic [NCAND-1:0] cand_req;
  logic [NCAND-1:0] cand_taken;
  logic [5:0]       slot_req;
  logic [NCAND-1:0] taken_or [7];

  assign cand_req = {periph_req,
                     debug_rx_full_req & ctrl_status_reg[pia_pkg::CSR_DBG_RX],
                     debug_tx_empty_req & ctrl_status_reg[pia_pkg::CSR_DBG_TX]};
  assign taken_or[0] = '0;

  genvar s;
  generate
    for (s = 0; s < 6; s++) begin : g_slot
      logic       sel_valid;
      logic [6:0] sel_off;
      assign sel_off   = slot_sel[s] - pia_pkg::VEC_DBG_TX;
      assign sel_valid = (slot_sel[s] >= pia_pkg::VEC_DBG_TX) &&
                         (sel_off < 7'(NCAND)); // [R07]
      assign slot_req[s] = sel_valid && cand_req[sel_off[4:0]]; // [R05] [R06]
      assign taken_or[s+1] = taken_or[s] |
        (sel_valid ? (NCAND'(1) << sel_off[4:0]) : '0); // [R23]
    end
  endgenerate
  assign cand_taken = taken_or[6];

  // Level request vectors, each bit ordered by vector number
  logic [2:0]  l3_core;
  logic [8:0]  l3_req;
  logic [3:0]  l2_req;
  logic [3:0]  l1_req;
  logic [NCAND-3:0] l0_req;
  logic [1:0]  l3_dbg;

  assign l3_core = {core_misalign_req, core_stack_ov_req, core_illegal_req}; // [R02]
  assign l3_dbg  = cand_req[1:0] & ~cand_taken[1:0];
  assign l3_req  = {core_pend_reg[PEND_TOP], l3_dbg,
                    core_trace_req & ctrl_status_reg[pia_pkg::CSR_TRACE],
                    core_brk_req   & ctrl_status_reg[pia_pkg::CSR_BRK],
                    core_step_req  & ctrl_status_reg[pia_pkg::CSR_STEP], // [R03]
                    l3_core}; // [R08]
  assign l2_req  = {slot_req[2*NS-1:NS], core_pend_reg[PEND_L2]}; // [R04] [R08]
  assign l1_req  = {slot_req[NS-1:0], core_pend_reg[PEND_L1]}; // [R04]
  assign l0_req  = periph_req & ~cand_taken[NCAND-1:2]; // [R21] [R23]

  // Per-level encoders
  logic       p3;
  logic       p2;
  logic       p1;
  logic       p0;
  logic [6:0] i3;
  logic [6:0] i2;
  logic [6:0] i1;
  logic [6:0] i0;

  pia_lowest_enc #(.N(9)) u_enc3 ( // [R09] [R10]
    .req     (l3_req),
    .pending (p3),
    .index   (i3)
  );
  pia_lowest_enc #(.N(4)) u_enc2 (
    .req     (l2_req),
    .pending (p2),
    .index   (i2)
  );
  pia_lowest_enc #(.N(4)) u_enc1 (
    .req     (l1_req),
    .pending (p1),
    .index   (i1)
  );
  pia_lowest_enc #(.N(pia_pkg::L0_COUNT)) u_enc0 (
    .req     (l0_req),
    .pending (p0),
    .index   (i0)
  );

  logic plp;
  assign plp = core_pend_reg[PEND_LOW];

  // Vector numbers of each level winner
  logic [6:0] v3;
  logic [6:0] v2;
  logic [6:0] v1;
  logic [6:0] v0;
  // Level-3 vectors below the top trap are contiguous from the illegal op
  assign v3 = (i3 < L3_TRAP_IDX) ? pia_pkg::VEC_ILLEGAL + i3 : pia_pkg::VEC_TRAP_TOP;
  assign v2 = (i2 == 7'h00) ? pia_pkg::VEC_TRAP_L2
                            : pia_pkg::VEC_L2_SLOT_A + i2 - 7'h01;
  assign v1 = (i1 == 7'h00) ? pia_pkg::VEC_TRAP_L1
                            : pia_pkg::VEC_L1_SLOT_A + i1 - 7'h01;
  assign v0 = pia_pkg::VEC_L0_FIRST + i0;

  // Sufficient priority against core mask and current level
  logic [1:0] cur_code;
  logic       ok3;
  logic       ok2;
  logic       ok1;
  logic       ok0;
  logic       oklp;
  assign cur_code = current_level_code;
  assign ok3  = 1'b1;
  assign ok2  = (core_mask_bits <= pia_pkg::MASK_L01) &&
                (cur_code < pia_pkg::LCODE_L23); // [R18] [R19]
  assign ok1  = (core_mask_bits <= pia_pkg::MASK_L0) &&
                (cur_code < pia_pkg::LCODE_L1);
  assign ok0  = (core_mask_bits == pia_pkg::MASK_ALL) &&
                (cur_code < pia_pkg::LCODE_L0);
  assign oklp = (core_mask_bits == pia_pkg::MASK_ALL) &&
                (cur_code == pia_pkg::LCODE_NONE);

  // Level arbitration, higher level first
  always_comb begin
    win_lvl_next = pia_pkg::PIA_LVL_NONE;
    win_vec_next = win_vec_reg;
    irq_next     = 1'b0;
    if (p3 && ok3) begin // [R11]
      win_lvl_next = pia_pkg::PIA_LVL_3;
      win_vec_next = v3;
      irq_next     = 1'b1;
    end else if (p2 && ok2) begin
      win_lvl_next = pia_pkg::PIA_LVL_2;
      win_vec_next = v2;
      irq_next     = 1'b1;
    end else if (p1 && ok1) begin
      win_lvl_next = pia_pkg::PIA_LVL_1;
      win_vec_next = v1;
      irq_next     = 1'b1;
    end else if (p0 && ok0) begin
      win_lvl_next = pia_pkg::PIA_LVL_0;
      win_vec_next = v0;
      irq_next     = 1'b1;
    end else if (plp && oklp) begin
      win_lvl_next = pia_pkg::PIA_LVL_LP;
      win_vec_next = pia_pkg::VEC_TRAP_LOW;
      irq_next     = 1'b1;
    end
  end

  // Fast interrupt: slot six wins at level 2, first insn not a call
  assign fast_next = irq_next && (win_lvl_next == pia_pkg::PIA_LVL_2) &&
                     (win_vec_next == pia_pkg::VEC_FAST) &&
                     !fast_first_is_sub; // [R20] [R22]

  // Wake: identical handling of wait/lp-wait and stop/lp-stop
  logic                      low_power;
  logic                      low_power_reg;
  logic                      any_enabled;
  logic [pia_pkg::CSR_W-1:0] wake_en_reg;
  logic [pia_pkg::CSR_W-1:0] wake_en_next;
  logic [pia_pkg::CSR_W-1:0] wake_dbg;
  assign low_power    = wait_mode | lowpower_wait_mode |
                        stop_mode | lowpower_stop_mode; // [R15]
  // Enables frozen on entry; only sources enabled beforehand may wake
  assign wake_en_next = low_power_reg ? wake_en_reg : ctrl_status_reg; // [R14]
  assign wake_dbg     = {debug_rx_full_req, debug_tx_empty_req, core_trace_req,
                         core_brk_req, core_step_req} & wake_en_next;
  assign any_enabled  = (|l3_core) | (|core_pend_reg) | (|periph_req) | (|wake_dbg);
  // Combinational so that it still reaches the clock unit with mclk stopped
  assign restart_next = low_power && any_enabled; // [R14]

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin // [R24]
      core_prev_reg <= '0;
      core_pend_reg <= '0;
    end else begin
      core_prev_reg <= core_lvl;
      core_pend_reg <= core_pend_next;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin // [R01]
      win_vec_reg  <= pia_pkg::SLOT_NONE;
      win_lvl_reg  <= pia_pkg::PIA_LVL_NONE;
      irq_reg      <= 1'b0;
      fast_reg     <= 1'b0;
      low_power_reg <= 1'b0;
      wake_en_reg  <= pia_pkg::CSR_RESET;
      rst_done_reg <= 1'b0;
    end else begin
      win_vec_reg  <= win_vec_next;
      win_lvl_reg  <= win_lvl_next;
      irq_reg      <= irq_next;
      fast_reg     <= fast_next;
      low_power_reg <= low_power;
      wake_en_reg  <= wake_en_next;
      rst_done_reg <= 1'b1;
    end
  end

  // Level code of the registered winner
  logic [1:0] code_of_win;
  always_comb begin
    case (win_lvl_reg)
      pia_pkg::PIA_LVL_0: code_of_win = pia_pkg::LCODE_L0;
      pia_pkg::PIA_LVL_1: code_of_win = pia_pkg::LCODE_L1;
      pia_pkg::PIA_LVL_2: code_of_win = pia_pkg::LCODE_L23;
      pia_pkg::PIA_LVL_3: code_of_win = pia_pkg::LCODE_L23;
      default:            code_of_win = pia_pkg::LCODE_NONE;
    endcase
  end

  // Current level follows the acknowledged winner
  logic [1:0] level_reg;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      level_reg <= pia_pkg::LCODE_NONE;
    end else if (hw_int_ack && irq_reg) begin
      level_reg <= code_of_win; // [R19]
    end else if (!irq_reg && core_mask_bits == pia_pkg::MASK_ALL) begin
      level_reg <= pia_pkg::LCODE_NONE;
    end
  end

  assign current_level_code  = level_reg;
  assign irq_to_core         = irq_reg;
  assign winning_vector      = win_vec_reg;
  assign fast_irq            = fast_reg;
  assign pending_core_events = core_pend_reg;
  assign vector_addr = rst_done_reg ? {vector_base_reg, 1'b0, win_vec_reg}
                                    : pia_pkg::RESET_ADDR; // [R16] [R17]
  assign clock_restart_req   = restart_next;
  assign irq_asserted        = irq_reg | restart_next; // [R15]
endmodule

// ### pia_arbiter_assertions.sv
`timescale 1ns/1ps
module pia_arbiter_chk (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        core_illegal_req,
  input wire logic        soft_trap_l1,
  input wire logic        soft_trap_l2,
  input wire logic        hw_int_ack,
  input wire logic [4:0]  ctrl_status_reg,
  input wire logic [12:0] vector_base_reg,
  input wire logic [6:0]  level1_slot_a,
  input wire logic [1:0]  core_mask_bits,
  input wire logic        irq_to_core,
  input wire logic [20:0] vector_addr,
  input wire logic [6:0]  winning_vector,
  input wire logic [4:0]  pending_core_events
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wire l0_win = irq_to_core && winning_vector >= pia_pkg::VEC_L0_FIRST
                && winning_vector < pia_pkg::VEC_TRAP_TOP;
  a_vec_concat: assert property (
    irq_to_core |-> vector_addr == {vector_base_reg, 1'b0, winning_vector})
    else $error("vector address mismatch");
  a_unmask_l3: assert property (
    core_illegal_req |=> irq_to_core && winning_vector == pia_pkg::VEC_ILLEGAL)
    else $error("illegal op not presented");
  a_step_gate: assert property (
    irq_to_core && winning_vector == pia_pkg::VEC_STEP_CNT
    |-> $past(ctrl_status_reg[pia_pkg::CSR_STEP]))
    else $error("step request passed while disabled");
  a_brk_gate: assert property (
    irq_to_core && winning_vector == pia_pkg::VEC_BREAKPT
    |-> $past(ctrl_status_reg[pia_pkg::CSR_BRK]))
    else $error("breakpoint passed while disabled");
  a_redirect_hide: assert property (
    l0_win |-> winning_vector != $past(level1_slot_a))
    else $error("redirected source on own vector");
  a_redirect_dbg: assert property (
    irq_to_core && (winning_vector == pia_pkg::VEC_DBG_TX ||
                    winning_vector == pia_pkg::VEC_DBG_RX)
    |-> winning_vector != $past(level1_slot_a))
    else $error("redirected debug source on own vector");
  a_mask_l0: assert property (
    l0_win |-> $past(core_mask_bits) == pia_pkg::MASK_ALL)
    else $error("level 0 passed a mask");
  a_mask_top: assert property (
    irq_to_core && $past(core_mask_bits) == 2'h3
    |-> winning_vector < pia_pkg::VEC_L0_FIRST || winning_vector == pia_pkg::VEC_TRAP_TOP)
    else $error("non level 3 passed full mask");
  a_trap_edge: assert property (
    $rose(soft_trap_l1) |=> pending_core_events[3])
    else $error("trap edge not pending");
  a_ack_clear: assert property (
    hw_int_ack && winning_vector == pia_pkg::VEC_TRAP_L2 && !$rose(soft_trap_l2)
    |=> !pending_core_events[2])
    else $error("acknowledge left trap pending");
endmodule

// ### pia_arbiter_bench.sv
`timescale 1ns/1ps
module pia_arbiter_bench;
  logic        mclk, arst_n, hw_int_ack, fast_first_is_sub, ack_en;
  logic        core_illegal_req, core_stack_ov_req, core_misalign_req;
  logic        core_step_req, core_brk_req, core_trace_req;
  logic        soft_trap_top, soft_trap_l2, soft_trap_l1, soft_trap_lowest;
  logic        debug_tx_empty_req, debug_rx_full_req;
  logic        wait_mode, stop_mode, lowpower_wait_mode, lowpower_stop_mode;
  logic        irq_to_core, fast_irq, clock_restart_req, irq_asserted;
  logic [21:0] periph_req;
  logic [4:0]  ctrl_status_reg, dbg_req, pending_core_events;
  logic [12:0] vector_base_reg;
  logic [6:0]  level1_slot_a, level1_slot_b, level1_slot_c, winning_vector;
  logic [6:0]  level2_slot_a, level2_slot_b, level2_fast_slot;
  logic [6:0]  slot [6];
  logic [3:0]  mode, trap_req, ack_dly;
  logic [2:0]  l3_req;
  logic [1:0]  core_mask_bits, mask_sel, current_level_code;
  logic [20:0] vector_addr;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  assign {debug_rx_full_req, debug_tx_empty_req, core_trace_req, core_brk_req,
          core_step_req} = dbg_req;
  assign {core_misalign_req, core_stack_ov_req, core_illegal_req} = l3_req;
  assign {soft_trap_lowest, soft_trap_l1, soft_trap_l2, soft_trap_top} = trap_req;
  assign {lowpower_stop_mode, stop_mode, lowpower_wait_mode, wait_mode} = mode;
  assign {level1_slot_a, level1_slot_b, level1_slot_c} = {slot[0], slot[1], slot[2]};
  assign {level2_slot_a, level2_slot_b, level2_fast_slot} = {slot[3], slot[4], slot[5]};
  pia_arbiter i_dut (.mclk, .arst_n, .core_illegal_req, .core_stack_ov_req,
    .core_misalign_req, .core_step_req, .core_brk_req, .core_trace_req, .soft_trap_top,
    .soft_trap_l2, .soft_trap_l1, .soft_trap_lowest, .debug_tx_empty_req,
    .debug_rx_full_req, .hw_int_ack, .periph_req, .ctrl_status_reg, .vector_base_reg,
    .level1_slot_a, .level1_slot_b, .level1_slot_c, .level2_slot_a, .level2_slot_b,
    .level2_fast_slot, .fast_first_is_sub, .core_mask_bits, .lowpower_wait_mode,
    .lowpower_stop_mode, .wait_mode, .stop_mode, .irq_to_core, .vector_addr,
    .winning_vector, .current_level_code, .fast_irq, .pending_core_events,
    .clock_restart_req, .irq_asserted);
  pia_core_model i_core (.mclk, .arst_n, .ack_en, .ack_dly, .mask_sel, .irq_to_core,
    .hw_int_ack, .core_mask_bits);
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic win(input logic [6:0] vec);
    for (int i = 0; i < 8 && irq_to_core !== 1'b1; i++) begin
      tick(1);
    end
    chk("irq_to_core", 21'(1), 21'(irq_to_core));
    chk("winning_vector", 21'(vec), 21'(winning_vector));
  endtask
  task automatic clr;
    periph_req = 22'h0;
    dbg_req = 5'h0;
    l3_req = 3'h0;
    trap_req = 4'h0;
    mode = 4'h0;
    ctrl_status_reg = 5'h0;
    mask_sel = 2'h0;
    ack_en = 1'b0;
    fast_first_is_sub = 1'b0;
    foreach (slot[j]) slot[j] = 7'h0;
    tick(4);
  endtask
  task automatic t_l0;
    periph_req = 22'h200080;
    win(7'h11);
    chk("vector_addr", {vector_base_reg, 1'b0, 7'h11}, vector_addr);
    clr;
  endtask
  task automatic t_l3;
    for (int i = 0; i < 3; i++) begin
      l3_req = 3'h1 << i;
      periph_req = 22'h1;
      win(7'(2 + i));
      clr;
    end
    l3_req = 3'h7;
    win(pia_pkg::VEC_ILLEGAL);
    clr;
  endtask
  task automatic t_gate;
    for (int i = 0; i < 5; i++) begin
      dbg_req = 5'h1 << i;
      slot[0] = (i == 4) ? pia_pkg::VEC_DBG_RX : 7'h0;
      tick(3);
      chk("irq_to_core", 21'(0), 21'(irq_to_core));
      ctrl_status_reg = 5'h1 << i;
      win((i == 4) ? pia_pkg::VEC_L1_SLOT_A : 7'(5 + i));
      clr;
    end
  endtask
  task automatic t_slot;
    for (int s = 0; s < 6; s++) begin
      slot[s] = 7'(11 + s);
      periph_req = 22'h1 | (22'h2 << s);
      win(7'(36 + s));
      chk("fast_irq", 21'(s == 5), 21'(fast_irq));
      clr;
    end
    slot[5] = 7'h0b;
    periph_req = 22'h2;
    fast_first_is_sub = 1'b1;
    win(pia_pkg::VEC_FAST);
    chk("fast_irq", 21'(0), 21'(fast_irq));
    clr;
  endtask
  task automatic t_mask;
    for (int m = 1; m < 4; m++) begin
      mask_sel = 2'(m);
      periph_req = 22'h1;
      tick(3);
      chk("irq_to_core", 21'(0), 21'(irq_to_core));
      l3_req = 3'h1;
      win(pia_pkg::VEC_ILLEGAL);
      clr;
    end
  endtask
  task automatic t_wake;
    for (int w = 0; w < 4; w++) begin
      mode = 4'h1 << w;
      dbg_req = 5'h1;
      tick(3);
      chk("clock_restart_req", 21'(0), 21'(clock_restart_req));
      ctrl_status_reg = 5'h1;
      tick(3);
      chk("clock_restart_req", 21'(0), 21'(clock_restart_req));
      periph_req = 22'h1;
      tick(3);
      chk("clock_restart_req", 21'(1), 21'(clock_restart_req));
      chk("irq_asserted", 21'(1), 21'(irq_asserted));
      clr;
    end
  endtask
  task automatic t_trap;
    for (int k = 0; k < 8; k++) begin
      ack_en = 1'b1;
      ack_dly = (k > 3) ? 4'h5 : 4'h0;
      trap_req = 4'h1 << (k % 4);
      tick(1);
      chk("pending", 21'(5'h2 << (k % 4)), 21'(pending_core_events));
      win(7'(32 + k % 4));
      for (int i = 0; i < 12 && hw_int_ack !== 1'b1; i++) begin
        tick(1);
      end
      tick(1);
      chk("pending", 21'(0), 21'(pending_core_events));
      chk("current_level_code", 21'(k % 4 == 3 ? pia_pkg::LCODE_NONE : k % 4 == 2 ?
          pia_pkg::LCODE_L1 : pia_pkg::LCODE_L23), 21'(current_level_code));
      clr;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #50000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    arst_n = 1'b0;
    vector_base_reg = 13'h1a5;
    ack_dly = 4'h0;
    clr;
    chk("vector_addr", 21'h0, vector_addr);
    chk("irq_to_core", 21'(0), 21'(irq_to_core));
    arst_n = 1'b1;
    tick(1);
    t_l0;
    t_l3;
    t_gate;
    t_slot;
    t_mask;
    t_wake;
    t_trap;
    print_verdict;
  end
endmodule
bind pia_arbiter pia_arbiter_chk u_chk (.mclk, .arst_n, .core_illegal_req, .soft_trap_l1,
  .soft_trap_l2, .hw_int_ack, .ctrl_status_reg, .vector_base_reg, .level1_slot_a,
  .core_mask_bits, .irq_to_core, .vector_addr, .winning_vector, .pending_core_events);

// ### pia_core_model.sv
`timescale 1ns/1ps
module pia_core_model (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_dly,
  input  wire logic [1:0] mask_sel,
  input  wire logic       irq_to_core,
  output logic            hw_int_ack,
  output logic [1:0]      core_mask_bits
);
  logic [4:0] wait_cnt_reg;
  assign core_mask_bits = mask_sel;
  // One acknowledge per request, after a chosen delay
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wait_cnt_reg <= 5'h00;
      hw_int_ack   <= 1'b0;
    end else begin
      wait_cnt_reg <= irq_to_core ? wait_cnt_reg + 5'h01 : 5'h00;
      hw_int_ack   <= ack_en && irq_to_core && wait_cnt_reg == {1'b0, ack_dly};
    end
  end
endmodule

// ### pia_lowest_enc.sv
`timescale 1ns/1ps
// Picks the lowest set request; index is position within the group
module pia_lowest_enc #(
  parameter int unsigned N = 8
) (
  input  wire logic [N-1:0] req,
  output logic              pending,
  output logic [6:0]        index
);
  logic [N-1:0] lower_any;
  logic [N-1:0] first_hot;
  logic [6:0]   idx_or [N:0];

  assign lower_any[0] = 1'b0;
  assign idx_or[0]    = 7'h00;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      if (g > 0) begin : g_chain
        assign lower_any[g] = lower_any[g-1] | req[g-1];
      end
      assign first_hot[g] = req[g] & ~lower_any[g];
      assign idx_or[g+1]  = idx_or[g] | (first_hot[g] ? 7'(g) : 7'h00);
    end
  endgenerate

  assign pending = |req;
  assign index   = idx_or[N];
endmodule

// ### pia_pkg.sv
package pia_pkg;
  // Vector numbers
  localparam int unsigned VEC_W        = 7;
  localparam logic [6:0] VEC_ILLEGAL   = 7'h02;
  localparam logic [6:0] VEC_STACK_OV  = 7'h03;
  localparam logic [6:0] VEC_MISALIGN  = 7'h04;
  localparam logic [6:0] VEC_STEP_CNT  = 7'h05;
  localparam logic [6:0] VEC_BREAKPT   = 7'h06;
  localparam logic [6:0] VEC_TRACE     = 7'h07;
  localparam logic [6:0] VEC_DBG_TX    = 7'h08;
  localparam logic [6:0] VEC_DBG_RX    = 7'h09;
  localparam logic [6:0] VEC_L0_FIRST  = 7'h0a;
  localparam int unsigned L0_COUNT     = 22;
  localparam logic [6:0] VEC_TRAP_TOP  = 7'h20;
  localparam logic [6:0] VEC_TRAP_L2   = 7'h21;
  localparam logic [6:0] VEC_TRAP_L1   = 7'h22;
  localparam logic [6:0] VEC_TRAP_LOW  = 7'h23;
  localparam logic [6:0] VEC_L1_SLOT_A = 7'h24;
  localparam logic [6:0] VEC_L2_SLOT_A = 7'h27;
  localparam logic [6:0] VEC_FAST      = 7'h29;
  // Slot selection encoding: vector number, zero means unused
  localparam logic [6:0] SLOT_NONE     = 7'h00;
  // Control and status bits
  localparam int unsigned CSR_W        = 5;
  localparam int unsigned CSR_STEP     = 0;
  localparam int unsigned CSR_BRK      = 1;
  localparam int unsigned CSR_TRACE    = 2;
  localparam int unsigned CSR_DBG_TX   = 3;
  localparam int unsigned CSR_DBG_RX   = 4;
  localparam logic [4:0] CSR_RESET     = 5'h00;
  // Address widths and reset values
  localparam int unsigned ADDR_W       = 21;
  localparam int unsigned VBA_W        = 13;
  localparam logic [12:0] VBA_RESET    = 13'h0000;
  localparam logic [20:0] RESET_ADDR   = 21'h000000;
  // Level codes
  localparam logic [1:0] LCODE_NONE    = 2'h0;
  localparam logic [1:0] LCODE_L0      = 2'h1;
  localparam logic [1:0] LCODE_L1      = 2'h2;
  localparam logic [1:0] LCODE_L23     = 2'h3;
  // Core mask values
  localparam logic [1:0] MASK_ALL      = 2'h0;
  localparam logic [1:0] MASK_L0       = 2'h1;
  localparam logic [1:0] MASK_L01      = 2'h2;
  // Winning level
  typedef enum logic [4:0] {
    PIA_LVL_NONE = 5'b00000,
    PIA_LVL_LP   = 5'b00001,
    PIA_LVL_0    = 5'b00010,
    PIA_LVL_1    = 5'b00100,
    PIA_LVL_2    = 5'b01000,
    PIA_LVL_3    = 5'b10000
  } pia_level_t;
endpackage
